// ---- core/adc_seq_pkg.sv ----
// Purpose: shared constants and types of the high-rate converter sequencer
// Assumes: 100 MHz system clock, 10-bit successive-approximation core
// Notes:   times are kept in picoseconds, cycle counts derived from them
package adc_seq_pkg;

  localparam int unsigned CLK_PERIOD_PS  = 10000;          // 10 ns system clock
  localparam int unsigned TAD_MIN_PS     = 83330;          // shortest conversion-clock period, 1 Msps
  // least time rounds up to whole cycles
  localparam int unsigned TAD_MIN_CYC_I  = (TAD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0]  TAD_MIN_CYC    = TAD_MIN_CYC_I[6:0];

  localparam logic [4:0]  CONV_TADS      = 5'h0c;          // 12 periods per conversion
  localparam logic [4:0]  SAMP_TADS_MIN  = 5'h01;          // a zero sample time still samples one period
  localparam logic [2:0]  TRIG_AUTO      = 3'h7;           // internal counter ends sampling
  localparam logic [1:0]  CHCNT_ONE      = 2'h0;           // one sample-and-hold channel
  localparam logic [1:0]  CHCNT_TWO      = 2'h1;           // two sample-and-hold channels

  localparam int unsigned RESULT_W       = 10;
  localparam int unsigned SLOT_W         = 4;
  localparam int unsigned ENTRY_W        = RESULT_W + SLOT_W;
  localparam int unsigned NUM_SH         = 4;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_t;

  typedef logic [ENTRY_W-1:0] entry_t;

endpackage

// ---- core/result_stream_if.sv ----
// Purpose: valid/ready word path between sequencer and result buffer
// Assumes: one clock domain
// Notes:   a word moves when valid and ready are both high at an edge
`timescale 1ns/10ps
interface result_stream_if;
  logic                  valid;
  logic                  ready;
  adc_seq_pkg::entry_t   data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- core/result_buffer.sv ----
// Purpose: two-entry result buffer so a stalled reader loses no word
// Assumes: synchronous active-high reset
// Notes:   head and tail are registers; outputs come straight from them
`timescale 1ns/10ps
module result_buffer
(
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  result_stream_if.snk    fill,
  result_stream_if.src    drain
);

  adc_seq_pkg::entry_t head_reg, head_next;
  adc_seq_pkg::entry_t tail_reg, tail_next;
  logic                head_vld_reg, head_vld_next;
  logic                tail_vld_reg, tail_vld_next;
  logic                push;
  logic                pop;

  // outputs taken directly from flip-flops
  assign drain.valid = head_vld_reg;
  assign drain.data  = head_reg;
  assign fill.ready  = ~tail_vld_reg;           // full when the tail is occupied

  // next head and tail
  always_comb
  begin
    push          = fill.valid & ~tail_vld_reg;
    pop           = head_vld_reg & drain.ready;
    head_next     = head_reg;
    tail_next     = tail_reg;
    head_vld_next = head_vld_reg;
    tail_vld_next = tail_vld_reg;
    if (pop)
    begin
      if (tail_vld_reg)
      begin
        head_next     = tail_reg;
        tail_vld_next = 1'b0;
      end
      else if (push)
      begin
        head_next = fill.data;
      end
      else
      begin
        head_vld_next = 1'b0;
      end
    end
    else if (push)
    begin
      if (!head_vld_reg)
      begin
        head_next     = fill.data;
        head_vld_next = 1'b1;
      end
      else
      begin
        tail_next     = fill.data;
        tail_vld_next = 1'b1;
      end
    end
  end

  // register stage
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      head_reg     <= '0;
      tail_reg     <= '0;
      head_vld_reg <= 1'b0;
      tail_vld_reg <= 1'b0;
    end
    else
    begin
      head_reg     <= head_next;
      tail_reg     <= tail_next;
      head_vld_reg <= head_vld_next;
      tail_vld_reg <= tail_vld_next;
    end
  end

endmodule // result_buffer

// ---- core/adc_high_rate_sequencer.sv ----
// Purpose: sample/convert sequencer of a 10-bit converter at high rates
// Assumes: I_CLK 100 MHz; analog core delivers its result on I_SAR_RESULT
//          by the end of the twelfth conversion period
// Notes:   configuration bits arrive as plain ports
`timescale 1ns/10ps
module adc_high_rate_sequencer
(
  input  wire logic                                I_CLK,
  input  wire logic                                I_RST,
  input  wire logic                                I_ENABLE,
  input  wire logic [2:0]                          I_TRIGGER_SOURCE_SEL,
  input  wire logic                                I_AUTO_SAMPLE_EN,
  input  wire logic                                I_SIMULTANEOUS_SAMPLE_EN,
  input  wire logic [1:0]                          I_SH_CHANNEL_COUNT,
  input  wire logic [3:0]                          I_CONVERSIONS_PER_IRQ,
  input  wire logic [5:0]                          I_CONV_CLOCK_SELECT,
  input  wire logic [4:0]                          I_AUTO_SAMPLE_TIME,
  input  wire logic                                I_SAMPLE_START,
  input  wire logic                                I_CONVERT_START,
  input  wire logic                                I_IRQ_CLEAR,
  input  wire logic [adc_seq_pkg::RESULT_W-1:0]    I_SAR_RESULT,
  input  wire logic                                I_RESULT_READY,
  output logic      [adc_seq_pkg::NUM_SH-1:0]      O_SH_HOLD,
  output logic      [1:0]                          O_CONV_CH,
  output logic                                     O_SAR_START,
  output logic                                     O_SAMPLING,
  output logic                                     O_CONV_DONE,
  output logic                                     O_IRQ_FLAG,
  output logic                                     O_RESULT_VALID,
  output logic      [adc_seq_pkg::RESULT_W-1:0]    O_RESULT_DATA,
  output logic      [adc_seq_pkg::SLOT_W-1:0]      O_RESULT_SLOT
);

  // period length in system cycles, clamped so the rate stays in range
  function automatic logic [6:0] tad_len(input logic [5:0] sel);
    logic [6:0] raw;
    raw = {1'b0, sel} + 7'h01;
    tad_len = (raw < adc_seq_pkg::TAD_MIN_CYC) ? adc_seq_pkg::TAD_MIN_CYC : raw;
  endfunction

  // index of the last taking-part channel
  function automatic logic [1:0] last_ch(input logic [1:0] cnt);
    case (cnt)
      adc_seq_pkg::CHCNT_ONE: last_ch = 2'h0;
      adc_seq_pkg::CHCNT_TWO: last_ch = 2'h1;
      default:                last_ch = 2'h3;
    endcase
  endfunction

  // mask of taking-part channels
  function automatic logic [3:0] ch_mask(input logic [1:0] cnt);
    case (cnt)
      adc_seq_pkg::CHCNT_ONE: ch_mask = 4'h1;
      adc_seq_pkg::CHCNT_TWO: ch_mask = 4'h3;
      default:                ch_mask = 4'hf;
    endcase
  endfunction

  adc_seq_pkg::seq_state_t state_reg, state_next;
  logic [6:0]              tad_cnt_reg, tad_cnt_next;
  logic [4:0]              ph_cnt_reg, ph_cnt_next;
  logic [1:0]              cur_reg, cur_next;
  logic [3:0]              hold_reg, hold_next;
  logic                    start_reg, start_next;
  logic                    sampling_reg, sampling_next;
  logic [3:0]              slot_reg, slot_next;
  logic                    irq_reg, irq_next;
  logic                    done_reg, done_next;
  logic                    push_vld_reg, push_vld_next;
  adc_seq_pkg::entry_t     push_data_reg, push_data_next;

  logic                    tad_tick;
  logic                    auto_conv;
  logic [4:0]              samp_len;
  logic [1:0]              last;
  logic                    irq_set;
  logic                    done_clr;

  result_stream_if push_if ();
  result_stream_if pop_if ();

  assign push_if.valid = push_vld_reg;
  assign push_if.data  = push_data_reg;
  assign pop_if.ready  = I_RESULT_READY;

  result_buffer u_buf
  (
    .I_CLK (I_CLK),
    .I_RST (I_RST),
    .fill  (push_if),
    .drain (pop_if)
  );

  // top outputs, all from flip-flops
  assign O_SH_HOLD      = hold_reg;
  assign O_CONV_CH      = cur_reg;
  assign O_SAR_START    = start_reg;
  assign O_SAMPLING     = sampling_reg;
  assign O_CONV_DONE    = done_reg;
  assign O_IRQ_FLAG     = irq_reg;
  assign O_RESULT_VALID = pop_if.valid;
  assign O_RESULT_DATA  = pop_if.data[adc_seq_pkg::RESULT_W-1:0];
  assign O_RESULT_SLOT  = pop_if.data[adc_seq_pkg::ENTRY_W-1:adc_seq_pkg::RESULT_W];

  // sequencer next state
  always_comb
  begin
    state_next     = state_reg;
    tad_cnt_next   = tad_cnt_reg;
    ph_cnt_next    = ph_cnt_reg;
    cur_next       = cur_reg;
    hold_next      = hold_reg;
    start_next     = 1'b0;
    slot_next      = slot_reg;
    push_data_next = push_data_reg;
    push_vld_next  = push_vld_reg & ~push_if.ready;
    irq_set        = 1'b0;
    done_clr       = 1'b0;
    tad_tick       = (tad_cnt_reg == tad_len(I_CONV_CLOCK_SELECT) - 7'h01);
    auto_conv      = (I_TRIGGER_SOURCE_SEL == adc_seq_pkg::TRIG_AUTO);
    samp_len       = (I_AUTO_SAMPLE_TIME < adc_seq_pkg::SAMP_TADS_MIN) ?
                     adc_seq_pkg::SAMP_TADS_MIN : I_AUTO_SAMPLE_TIME;
    last           = last_ch(I_SH_CHANNEL_COUNT);
    if (!I_ENABLE)
    begin
      state_next   = adc_seq_pkg::ST_IDLE;
      tad_cnt_next = 7'h00;
      ph_cnt_next  = 5'h00;
      hold_next    = 4'h0;
    end
    else
    begin
      case (state_reg)
        adc_seq_pkg::ST_IDLE:
        begin
          tad_cnt_next = 7'h00;
          ph_cnt_next  = 5'h00;
          if (I_AUTO_SAMPLE_EN || I_SAMPLE_START)
          begin
            state_next = adc_seq_pkg::ST_SAMPLE;
            cur_next   = 2'h0;
            hold_next  = 4'h0;
            done_clr   = 1'b1;
          end
        end
        adc_seq_pkg::ST_SAMPLE:
        begin
          tad_cnt_next = tad_tick ? 7'h00 : tad_cnt_reg + 7'h01;
          if (tad_tick)
          begin
            ph_cnt_next = ph_cnt_reg + 5'h01;
          end
          if (auto_conv ? (tad_tick && ph_cnt_reg == samp_len - 5'h01) : I_CONVERT_START)
          begin
            state_next   = adc_seq_pkg::ST_CONVERT;
            tad_cnt_next = 7'h00;
            ph_cnt_next  = 5'h00;
            start_next   = 1'b1;
            hold_next    = I_SIMULTANEOUS_SAMPLE_EN ? ch_mask(I_SH_CHANNEL_COUNT) :
                           (4'h1 << cur_reg);
          end
        end
        adc_seq_pkg::ST_CONVERT:
        begin
          if (tad_tick && ph_cnt_reg == adc_seq_pkg::CONV_TADS - 5'h01)
          begin
            if (push_vld_reg && !push_if.ready)
            begin
              // reader stalled and buffer full: hold at the last period
              tad_cnt_next = tad_cnt_reg;
            end
            else
            begin
              tad_cnt_next   = 7'h00;
              ph_cnt_next    = 5'h00;
              push_vld_next  = 1'b1;
              push_data_next = {slot_reg, I_SAR_RESULT};
              if (slot_reg == I_CONVERSIONS_PER_IRQ)
              begin
                slot_next = 4'h0;
                irq_set   = 1'b1;
              end
              else
              begin
                slot_next = slot_reg + 4'h1;
              end
              if (last == 2'h0)
              begin
                // single channel: sample again if auto sampling is on, else go idle
                hold_next  = 4'h0;
                state_next = I_AUTO_SAMPLE_EN ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
              end
              else if (I_SIMULTANEOUS_SAMPLE_EN)
              begin
                if (cur_reg != last)
                begin
                  cur_next   = cur_reg + 2'h1;
                  start_next = 1'b1;
                end
                else
                begin
                  cur_next   = 2'h0;
                  hold_next  = 4'h0;
                  state_next = I_AUTO_SAMPLE_EN ? adc_seq_pkg::ST_SAMPLE : adc_seq_pkg::ST_IDLE;
                end
              end
              else
              begin
                // ping-pong: release this channel, hold the one that was acquiring
                cur_next  = (cur_reg == last) ? 2'h0 : cur_reg + 2'h1;
                hold_next = (4'h1 << cur_next);
                if (cur_reg == last && !I_AUTO_SAMPLE_EN)
                begin
                  hold_next  = 4'h0;
                  state_next = adc_seq_pkg::ST_IDLE;
                end
                else
                begin
                  start_next = 1'b1;
                end
              end
            end
          end
          else
          begin
            tad_cnt_next = tad_tick ? 7'h00 : tad_cnt_reg + 7'h01;
            if (tad_tick)
            begin
              ph_cnt_next = ph_cnt_reg + 5'h01;
            end
          end
        end
        default:
        begin
          state_next = adc_seq_pkg::ST_IDLE;
        end
      endcase
    end
    sampling_next = (state_next == adc_seq_pkg::ST_SAMPLE);
    // set wins over clear on both flags
    irq_next  = irq_set | (irq_reg & ~I_IRQ_CLEAR);
    done_next = irq_set | (done_reg & ~done_clr);
  end

  // sequencer registers
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_reg     <= adc_seq_pkg::ST_IDLE;
      tad_cnt_reg   <= 7'h00;
      ph_cnt_reg    <= 5'h00;
      cur_reg       <= 2'h0;
      hold_reg      <= 4'h0;
      start_reg     <= 1'b0;
      sampling_reg  <= 1'b0;
      slot_reg      <= 4'h0;
      irq_reg       <= 1'b0;
      done_reg      <= 1'b0;
      push_vld_reg  <= 1'b0;
      push_data_reg <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      tad_cnt_reg   <= tad_cnt_next;
      ph_cnt_reg    <= ph_cnt_next;
      cur_reg       <= cur_next;
      hold_reg      <= hold_next;
      start_reg     <= start_next;
      sampling_reg  <= sampling_next;
      slot_reg      <= slot_next;
      irq_reg       <= irq_next;
      done_reg      <= done_next;
      push_vld_reg  <= push_vld_next;
      push_data_reg <= push_data_next;
    end
  end

endmodule // adc_high_rate_sequencer

// ---- tb/adc_seq_checker.sv ----
// Purpose: port-level checks of the converter sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every sequencer instance
`timescale 1ns/10ps
module adc_seq_checker
(
  input wire logic                             I_CLK,
  input wire logic                             I_RST,
  input wire logic                             I_ENABLE,
  input wire logic                             I_SIMULTANEOUS_SAMPLE_EN,
  input wire logic                             I_AUTO_SAMPLE_EN,
  input wire logic                             I_CONVERT_START,
  input wire logic                             I_IRQ_CLEAR,
  input wire logic                             I_RESULT_READY,
  input wire logic [2:0]                       I_TRIGGER_SOURCE_SEL,
  input wire logic [1:0]                       I_SH_CHANNEL_COUNT,
  input wire logic [3:0]                       I_CONVERSIONS_PER_IRQ,
  input wire logic [5:0]                       I_CONV_CLOCK_SELECT,
  input wire logic [4:0]                       I_AUTO_SAMPLE_TIME,
  input wire logic [adc_seq_pkg::NUM_SH-1:0]   O_SH_HOLD,
  input wire logic                             O_SAR_START,
  input wire logic                             O_SAMPLING,
  input wire logic                             O_CONV_DONE,
  input wire logic                             O_IRQ_FLAG,
  input wire logic                             O_RESULT_VALID,
  input wire logic [adc_seq_pkg::RESULT_W-1:0] O_RESULT_DATA,
  input wire logic [adc_seq_pkg::SLOT_W-1:0]   O_RESULT_SLOT
);
  logic [11:0] gap_reg, gap_next, samp_reg, samp_next, per, tn, samp_exp;
  default clocking dc @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // cycles since last conversion start, cycles of current sampling
  always_comb
  begin
    gap_next  = O_SAR_START ? 12'h001 : ((gap_reg == 12'hfff) ? gap_reg : gap_reg + 12'h001);
    samp_next = O_SAMPLING ? samp_reg + 12'h001 : 12'h000;
    per       = (I_CONV_CLOCK_SELECT < 6'h08) ? 12'h009 : {6'h00, I_CONV_CLOCK_SELECT} + 12'h001;
    tn        = (I_AUTO_SAMPLE_TIME == 5'h00) ? 12'h001 : {7'h00, I_AUTO_SAMPLE_TIME};
    samp_exp  = tn * per;
  end
  // helper registers
  always_ff @(posedge I_CLK)
  begin
    gap_reg  <= I_RST ? 12'hfff : gap_next;
    samp_reg <= I_RST ? 12'h000 : samp_next;
  end
  pulse_once_a: assert property (O_SAR_START |=> !O_SAR_START)
    else $error("conversion start longer than one cycle");
  conv_spacing_a: assert property (O_SAR_START |-> gap_reg >= 12'h06c)
    else $error("conversions closer than twelve shortest periods");
  samp_length_a: assert property ($fell(O_SAMPLING) && $past(I_ENABLE) && I_TRIGGER_SOURCE_SEL == 3'h7
    && I_SH_CHANNEL_COUNT == 2'h0 |-> samp_reg == samp_exp)
    else $error("sampling length differs from programmed time");
  single_hold_a: assert property (I_SH_CHANNEL_COUNT == 2'h0 |-> O_SH_HOLD[3:1] == 3'h0)
    else $error("extra hold channel used in single mode");
  one_at_time_a: assert property (!I_SIMULTANEOUS_SAMPLE_EN |-> $onehot0(O_SH_HOLD))
    else $error("more than one channel held in sequential mode");
  single_conv_a: assert property (O_SAR_START && I_SH_CHANNEL_COUNT == 2'h0
    |-> O_SH_HOLD == 4'h1 && $past(O_SAMPLING))
    else $error("single channel conversion not after sampling");
  manual_end_a: assert property (O_SAR_START && $past(O_SAMPLING) && $past(I_TRIGGER_SOURCE_SEL) != 3'h7
    |-> $past(I_CONVERT_START))
    else $error("manual trigger conversion without convert start");
  auto_resample_a: assert property (O_SAR_START && I_AUTO_SAMPLE_EN && I_SH_CHANNEL_COUNT == 2'h0
    |-> ##[100:1000] (O_SAMPLING || !I_ENABLE))
    else $error("sampling did not restart after conversion");
  irq_done_a: assert property ($rose(O_IRQ_FLAG) |-> O_CONV_DONE)
    else $error("interrupt without done");
  irq_clear_a: assert property ($fell(O_IRQ_FLAG) |-> $past(I_IRQ_CLEAR))
    else $error("interrupt flag dropped without clear");
  stall_hold_a: assert property (O_RESULT_VALID && !I_RESULT_READY
    |=> O_RESULT_VALID && $stable(O_RESULT_DATA) && $stable(O_RESULT_SLOT))
    else $error("result changed while reader stalled");
  slot_range_a: assert property (O_RESULT_VALID |-> O_RESULT_SLOT <= I_CONVERSIONS_PER_IRQ)
    else $error("result slot beyond interrupt count");
endmodule // adc_seq_checker

bind adc_high_rate_sequencer adc_seq_checker i_adc_seq_checker
(
  .I_CLK(I_CLK), .I_RST(I_RST), .I_ENABLE(I_ENABLE), .I_SIMULTANEOUS_SAMPLE_EN(I_SIMULTANEOUS_SAMPLE_EN),
  .I_AUTO_SAMPLE_EN(I_AUTO_SAMPLE_EN), .I_CONVERT_START(I_CONVERT_START), .I_IRQ_CLEAR(I_IRQ_CLEAR),
  .I_RESULT_READY(I_RESULT_READY), .I_TRIGGER_SOURCE_SEL(I_TRIGGER_SOURCE_SEL),
  .I_SH_CHANNEL_COUNT(I_SH_CHANNEL_COUNT), .I_CONVERSIONS_PER_IRQ(I_CONVERSIONS_PER_IRQ),
  .I_CONV_CLOCK_SELECT(I_CONV_CLOCK_SELECT), .I_AUTO_SAMPLE_TIME(I_AUTO_SAMPLE_TIME),
  .O_SH_HOLD(O_SH_HOLD), .O_SAR_START(O_SAR_START), .O_SAMPLING(O_SAMPLING), .O_CONV_DONE(O_CONV_DONE),
  .O_IRQ_FLAG(O_IRQ_FLAG), .O_RESULT_VALID(O_RESULT_VALID), .O_RESULT_DATA(O_RESULT_DATA),
  .O_RESULT_SLOT(O_RESULT_SLOT)
);

// ---- tb/adc_analog_model.sv ----
// Purpose: analog side stand-in, one input pin behind every hold channel
// Assumes: result line is read at the end of each conversion
// Notes:   word is {channel, conversion number}; toggled pattern after reset
`timescale 1ns/10ps
module adc_analog_model
(
  input  wire logic       I_CLK,
  input  wire logic       I_RST,
  input  wire logic       I_SAR_START,
  input  wire logic [1:0] I_CONV_CH,
  output logic      [9:0] O_RESULT
);
  logic [7:0] count_reg;
  // one word per conversion start, tagged with the channel being converted
  always @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      count_reg <= 8'h00;
      O_RESULT  <= 10'h2aa;
    end
    else if (I_SAR_START)
    begin
      count_reg <= count_reg + 8'h01;
      O_RESULT  <= {I_CONV_CH, count_reg};
    end
  end
endmodule // adc_analog_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench of the converter sequencer
// Assumes: 100 MHz clock, words checked as {channel, conversion number}
// Notes:   each test starts from reset with its own configuration
`timescale 1ns/10ps
module tb;
  logic       clk = 1'b0, rst = 1'b1, en = 1'b0, sim = 1'b0, auto_on = 1'b0;
  logic       s_go = 1'b0, c_go = 1'b0, clr = 1'b0, rdy = 1'b0;
  logic [2:0] trig = 3'h7;
  logic [1:0] cnt = 2'h0;
  logic [3:0] irqn = 4'h0;
  logic [5:0] sel = 6'h08;
  logic [4:0] stime = 5'h02;
  logic [3:0] hold, slot;
  logic [9:0] sar, data;
  logic [1:0] ch;
  logic       start, samp, done, irq, valid;
  logic [5:0] sel_tab [3] = '{6'h00, 6'h0c, 6'h08};
  logic [4:0] st_tab [3] = '{5'h02, 5'h02, 5'h00};
  int         err_count = 0, checks_done = 0, g;
  time        t_prev, t_last;

  // 100 MHz clock
  always #5 clk = ~clk;

  adc_high_rate_sequencer i_adc_high_rate_sequencer
  (
    .I_CLK(clk), .I_RST(rst), .I_ENABLE(en), .I_TRIGGER_SOURCE_SEL(trig), .I_AUTO_SAMPLE_EN(auto_on),
    .I_SIMULTANEOUS_SAMPLE_EN(sim), .I_SH_CHANNEL_COUNT(cnt), .I_CONVERSIONS_PER_IRQ(irqn),
    .I_CONV_CLOCK_SELECT(sel), .I_AUTO_SAMPLE_TIME(stime), .I_SAMPLE_START(s_go), .I_CONVERT_START(c_go),
    .I_IRQ_CLEAR(clr), .I_SAR_RESULT(sar), .I_RESULT_READY(rdy), .O_SH_HOLD(hold), .O_CONV_CH(ch),
    .O_SAR_START(start), .O_SAMPLING(samp), .O_CONV_DONE(done), .O_IRQ_FLAG(irq),
    .O_RESULT_VALID(valid), .O_RESULT_DATA(data), .O_RESULT_SLOT(slot)
  );

  adc_analog_model i_adc_analog_model
  (
    .I_CLK(clk), .I_RST(rst), .I_SAR_START(start), .I_CONV_CH(ch), .O_RESULT(sar)
  );

  // compare one value, count and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checks_done++;
      if (got !== exp)
      begin
        err_count++;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // verdict and end of run
  task automatic wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // reset for six cycles with a new configuration, enable on release
  task automatic setup(input logic [2:0] t, input logic a, s, input logic [1:0] c, input logic [3:0] n,
                       input logic [5:0] p, input logic [4:0] st);
    begin
      @(posedge clk);
      rst <= 1'b1;
      rdy <= 1'b1;
      {trig, auto_on, sim, cnt, irqn, sel, stime} <= {t, a, s, c, n, p, st};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      en  <= 1'b1;
    end
  endtask

  // take words with ready high; check word, slot, flags and spacing of the last two words
  task automatic stream(input int words, input int chs, input int gap);
    int k;
    begin
      for (int w = 0; w < words; w++)
      begin
        k = 0;
        do
        begin
          @(negedge clk);
          k++;
        end
        while (valid !== 1'b1 && k < 3000);
        if (valid !== 1'b1)
        begin
          chk({15'h0000, valid}, 16'h0001);
          wrap_up();
        end
        t_prev = t_last;
        t_last = $time;
        chk({6'h00, data}, {6'h00, 2'(w % chs), w[7:0]});
        chk({12'h000, slot}, 16'(w % (irqn + 1)));
        if (chs == 4 && w == 0)
          chk({12'h000, hold}, 16'h000f);
        if (w % (irqn + 1) == irqn)
          chk({14'h0000, irq, done}, 16'h0003);
        @(posedge clk);
        if (w % (irqn + 1) == irqn)
        begin
          clr <= 1'b1;
          @(posedge clk);
          clr <= 1'b0;
          @(negedge clk);
          chk({15'h0000, irq}, 16'h0000);
        end
      end
      if (gap > 0)
        chk(16'((t_last - t_prev) / 10), 16'(gap));
    end
  endtask

  initial
  begin
    // manual start and manual end of sampling
    setup(3'h0, 1'b0, 1'b0, 2'h0, 4'h0, 6'h08, 5'h02);
    @(negedge clk);
    chk({7'h00, hold, samp, done, irq, valid, start}, 16'h0000);
    repeat (50) @(posedge clk);
    chk({15'h0000, samp}, 16'h0000);
    s_go <= 1'b1;
    @(posedge clk);
    s_go <= 1'b0;
    repeat (40) @(posedge clk);
    chk({14'h0000, samp, valid}, 16'h0002);
    c_go <= 1'b1;
    @(posedge clk);
    c_go <= 1'b0;
    stream(1, 1, 0);
    repeat (300) @(posedge clk);
    chk({14'h0000, samp, valid}, 16'h0000);
    $display("test manual done");
    // single channel auto mode at three clock settings
    for (int i = 0; i < 3; i++)
    begin
      setup(3'h7, 1'b1, 1'b0, 2'h0, 4'h1, sel_tab[i], st_tab[i]);
      g = (12 + ((st_tab[i] == 5'h00) ? 1 : int'(st_tab[i]))) * ((sel_tab[i] < 6'h08) ? 9 : int'(sel_tab[i]) + 1);
      stream(3, 1, g);
      $display("test single channel %0d done", i);
    end
    // two channels sequential, full rate
    setup(3'h7, 1'b1, 1'b0, 2'h1, 4'h1, 6'h08, 5'h02);
    stream(5, 2, 108);
    // converter switched off mid-run: holds released, no restart
    @(posedge clk);
    en <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk({11'h000, hold, samp}, 16'h0000);
    $display("test two channel done");
    // four channels simultaneous
    setup(3'h7, 1'b1, 1'b1, 2'h2, 4'h3, 6'h08, 5'h02);
    stream(4, 4, 0);
    $display("test four channel done");
    // reader stalls, buffer fills, no word lost
    setup(3'h7, 1'b1, 1'b0, 2'h0, 4'hf, 6'h08, 5'h02);
    @(posedge clk);
    rdy <= 1'b0;
    repeat (600) @(posedge clk);
    rdy <= 1'b1;
    stream(6, 1, 0);
    $display("test stall done");
    wrap_up();
  end
endmodule // tb
